// file: rtl/sts_usart_slave.v
`timescale 1ns/1ps
`include "sts_defs.vh"
module sts_usart_slave #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              clock_pin_i,
  output wire              clock_pin_o,
  output wire              clock_pin_oe_n,
  input  wire              data_pin_i,
  output reg               data_pin_o,
  output wire              data_pin_oe_n,
  output wire              wake,
  output wire              vector_isr,
  output wire [15:0]       vector_addr
);
  // control registers
  reg [7:0] intctl_reg;
  reg [7:0] pie_reg;
  reg [7:0] rsc_reg;
  reg [7:0] tsc_reg;
  reg       sleep_reg;

  // transmit side: buffer, shift register and flag
  reg [7:0] txbuf_reg;
  reg       txbuf_full_reg;
  reg       tx_ninth_buf_reg;
  reg [8:0] tx_shift_reg;
  reg [3:0] tx_cnt_reg;
  reg       tx_busy_reg;
  reg       tx_flag_reg;

  // receive side: shift register and two-deep fifo
  reg [8:0] rx_shift_reg;
  reg [3:0] rx_cnt_reg;
  reg [8:0] fifo_mem [0:1];
  reg       fifo_rd_reg;
  reg [1:0] fifo_cnt_reg;
  reg       overrun_reg;

  // link pin synchronisers and edge detect
  reg [1:0] ck_sync_reg;
  reg [1:0] dt_sync_reg;
  reg       ck_prev_reg;

  // next values, worked out by the combinational processes below
  reg [7:0] txbuf_next;
  reg       txbuf_full_next;
  reg       tx_ninth_buf_next;
  reg [8:0] tx_shift_next;
  reg [3:0] tx_cnt_next;
  reg       tx_busy_next;
  reg       tx_flag_next;
  reg       data_out_next;
  reg [8:0] rx_shift_next;
  reg [3:0] rx_cnt_next;
  reg       fifo_rd_next;
  reg [1:0] fifo_cnt_next;
  reg       overrun_next;
  reg       fifo_we;

  // control bit decode
  wire port_en     = rsc_reg[`STS_RSC_PORT_EN];
  wire cont_rx_en  = rsc_reg[`STS_RSC_RX_CONT];
  wire once_rx_en  = rsc_reg[`STS_RSC_RX_ONCE];
  wire rx_nine_en  = rsc_reg[`STS_RSC_RX_NINE];
  wire tx_nine_en  = tsc_reg[`STS_TSC_TX_NINE];
  wire tx_en       = tsc_reg[`STS_TSC_TX_EN];
  wire sync_sel    = tsc_reg[`STS_TSC_SYNC];
  wire clk_src_sel = tsc_reg[`STS_TSC_CLK_SRC];

  // slave mode decode
  wire slave_mode = sync_sel & ~clk_src_sel & port_en;
  // single receive enable is a don't care once continuous receive is set
  wire rx_mode    = slave_mode & cont_rx_en;
  wire tx_mode    = slave_mode & ~cont_rx_en & ~once_rx_en & tx_en;

  // link clock edges; clock and data pass the same two flops, so they stay aligned
  // and a data bit sampled at a trailing edge is the one the master set up
  wire ck         = ck_sync_reg[1];
  wire ck_lead    = ck & ~ck_prev_reg;
  wire ck_trail   = ~ck & ck_prev_reg;
  wire [3:0] tx_bits = tx_nine_en ? `STS_BITS_NINE : `STS_BITS_BYTE;
  wire [3:0] rx_bits = rx_nine_en ? `STS_BITS_NINE : `STS_BITS_BYTE;

  // status seen by software
  wire sr_empty   = ~tx_busy_reg;
  wire rx_flag    = (fifo_cnt_reg != 2'h0);
  wire [8:0] fifo_top = fifo_mem[fifo_rd_reg];

  // receive helpers: one sampled bit, the last bit of a word, the shifted word
  wire rx_bit     = rx_mode & ck_trail & ~overrun_reg;
  wire rx_last    = (rx_cnt_reg == rx_bits - 4'h1);
  wire [8:0] rx_shift_in = rx_nine_en ? {dt_sync_reg[1], rx_shift_reg[8:1]}
                                      : {1'b0, dt_sync_reg[1], rx_shift_reg[7:1]};
  // the free slot is the top when empty and one past it with one word; a pop in the same cycle frees the top
  // itself only when the fifo is full, which this sum already yields
  wire fifo_wa    = fifo_rd_reg ^ fifo_cnt_reg[0];

  // pins: clock never driven in slave mode, data driven only when sending
  assign clock_pin_o    = 1'b0;
  assign clock_pin_oe_n = 1'b1;
  assign data_pin_oe_n  = ~tx_mode;

  // wake and vector outputs; the wake is a level, it stays until a flag clears
  assign wake = intctl_reg[`STS_INTCTL_PERIPH_EN] &
                ((tx_flag_reg & pie_reg[`STS_PI_TX]) |
                 (rx_flag & pie_reg[`STS_PI_RC]));
  assign vector_isr  = wake & intctl_reg[`STS_INTCTL_GLOBAL_EN];
  assign vector_addr = `STS_ISR_VECTOR;

  // axi write channel: accept address and data together
  wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  wire wr_en   = wr_fire & s_axi_wstrb[0];
  wire [ADDR_W-1:0] wa = s_axi_awaddr;
  wire wr_known = (wa == `STS_OFF_INTCTL) | (wa == `STS_OFF_PIE) | (wa == `STS_OFF_PIR) |
                  (wa == `STS_OFF_RSC) | (wa == `STS_OFF_TXBUF) | (wa == `STS_OFF_TSC) |
                  (wa == `STS_OFF_RXFIFO) | (wa == `STS_OFF_SLEEP);
  wire wr_txbuf = wr_en & (wa == `STS_OFF_TXBUF);
  wire wr_rsc   = wr_en & (wa == `STS_OFF_RSC);

  // axi read channel
  wire rd_fire = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_fire;
  wire rd_fifo = rd_fire & (s_axi_araddr == `STS_OFF_RXFIFO) & rx_flag;

  // bus response registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `STS_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `STS_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `STS_RESP_OKAY : `STS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `STS_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (s_axi_araddr)
          `STS_OFF_INTCTL: s_axi_rdata[7:0] <= intctl_reg;
          `STS_OFF_PIE:    s_axi_rdata[7:0] <= pie_reg;
          `STS_OFF_PIR:    s_axi_rdata[7:0] <= {2'h0, rx_flag, tx_flag_reg, 4'h0};
          `STS_OFF_RSC:    s_axi_rdata[7:0] <= {rsc_reg[7:3], 1'b0, overrun_reg,
                                                fifo_top[8] & rx_flag};
          `STS_OFF_TXBUF:  s_axi_rdata[7:0] <= 8'h00;
          `STS_OFF_TSC:    s_axi_rdata[7:0] <= {tsc_reg[7:4], 2'h0, sr_empty,
                                                tsc_reg[`STS_TSC_TX_BIT8]};
          `STS_OFF_RXFIFO: s_axi_rdata[7:0] <= rx_flag ? fifo_top[7:0] : 8'h00;
          `STS_OFF_SLEEP:  s_axi_rdata[0]   <= sleep_reg;
          default:         s_axi_rresp      <= `STS_RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // software written control registers; sleep bit clears on wake
  always @(posedge aclk) begin
    if (!aresetn) begin
      intctl_reg <= `STS_RST_BYTE;
      pie_reg    <= `STS_RST_BYTE;
      rsc_reg    <= `STS_RST_BYTE;
      tsc_reg    <= `STS_RST_TSC;
      sleep_reg  <= 1'b0;
    end else begin
      if (wr_en && wa == `STS_OFF_INTCTL) intctl_reg <= s_axi_wdata[7:0];
      if (wr_en && wa == `STS_OFF_PIE)    pie_reg    <= s_axi_wdata[7:0];
      if (wr_rsc) rsc_reg <= {s_axi_wdata[7:3], 3'b000};
      if (wr_en && wa == `STS_OFF_TSC)    tsc_reg    <= s_axi_wdata[7:0];
      if (wake) sleep_reg <= 1'b0;
      else if (wr_en && wa == `STS_OFF_SLEEP) sleep_reg <= s_axi_wdata[0];
    end
  end

  // two-flop synchronisers on link pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      ck_sync_reg <= 2'b00;
      dt_sync_reg <= 2'b00;
      ck_prev_reg <= 1'b0;
    end else begin
      ck_sync_reg <= {ck_sync_reg[0], clock_pin_i};
      dt_sync_reg <= {dt_sync_reg[0], data_pin_i};
      ck_prev_reg <= ck;
    end
  end

  // transmit next state: buffer write, load of the shift register, shifting.
  // the shift register only moves on link clock edges, so it keeps working
  // while the processor sleeps; the master decides when each bit goes out.
  // a buffer write in the cycle of a load refills the buffer, so the flag
  // stays clear then: the flag reports an empty buffer, not a finished load.
  always @* begin
    txbuf_next        = txbuf_reg;
    txbuf_full_next   = txbuf_full_reg;
    tx_ninth_buf_next = tx_ninth_buf_reg;
    tx_shift_next     = tx_shift_reg;
    tx_cnt_next       = tx_cnt_reg;
    tx_busy_next      = tx_busy_reg;
    tx_flag_next      = tx_flag_reg;
    data_out_next     = data_pin_o;
    if (wr_txbuf) begin
      txbuf_next        = s_axi_wdata[7:0];
      tx_ninth_buf_next = tsc_reg[`STS_TSC_TX_BIT8];
      txbuf_full_next   = 1'b1;
      tx_flag_next      = 1'b0;
    end
    if (!tx_mode) begin
      // leaving transmit drops the word in flight; an empty buffer raises the flag
      tx_busy_next = 1'b0;
      tx_cnt_next  = 4'h0;
      if (!wr_txbuf && !txbuf_full_reg) begin
        tx_flag_next = 1'b1;
      end
    end else if (!tx_busy_reg && txbuf_full_reg) begin
      // idle shift register takes the buffered word at once
      tx_shift_next   = {tx_ninth_buf_reg, txbuf_reg};
      tx_busy_next    = 1'b1;
      tx_cnt_next     = 4'h0;
      txbuf_full_next = wr_txbuf;
      if (!wr_txbuf) begin
        tx_flag_next = 1'b1;
      end
    end else if (tx_busy_reg && ck_lead) begin
      // leading edge changes the data bit, lsb first; works in sleep
      data_out_next = tx_shift_reg[0];
      tx_shift_next = {1'b0, tx_shift_reg[8:1]};
      tx_cnt_next   = tx_cnt_reg + 4'h1;
    end else if (tx_busy_reg && ck_trail && tx_cnt_reg == tx_bits) begin
      // the last bit has been held across its trailing edge
      tx_busy_next = 1'b0;
    end
  end

  // transmit registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      txbuf_reg        <= `STS_RST_BYTE;
      txbuf_full_reg   <= 1'b0;
      tx_ninth_buf_reg <= 1'b0;
      tx_shift_reg     <= 9'h000;
      tx_cnt_reg       <= 4'h0;
      tx_busy_reg      <= 1'b0;
      tx_flag_reg      <= 1'b0;
      data_pin_o       <= 1'b0;
    end else begin
      txbuf_reg        <= txbuf_next;
      txbuf_full_reg   <= txbuf_full_next;
      tx_ninth_buf_reg <= tx_ninth_buf_next;
      tx_shift_reg     <= tx_shift_next;
      tx_cnt_reg       <= tx_cnt_next;
      tx_busy_reg      <= tx_busy_next;
      tx_flag_reg      <= tx_flag_next;
      data_pin_o       <= data_out_next;
    end
  end

  // receive next state: sample on trailing edges, lsb first, then push the
  // word into the fifo. a full fifo with no read in the same cycle raises
  // overrun and freezes the receiver; stored words are never overwritten.
  // a read that meets a completing word makes room for it, so no overrun.
  always @* begin
    rx_shift_next = rx_shift_reg;
    rx_cnt_next   = rx_cnt_reg;
    fifo_rd_next  = fifo_rd_reg;
    fifo_cnt_next = fifo_cnt_reg;
    overrun_next  = overrun_reg;
    fifo_we       = 1'b0;
    if (!rx_mode) begin
      rx_cnt_next  = 4'h0;                                  // partial word dropped
      overrun_next = 1'b0;
    end else if (rx_bit) begin
      rx_shift_next = rx_shift_in;
      rx_cnt_next   = rx_last ? 4'h0 : rx_cnt_reg + 4'h1;
    end
    if (rx_bit && rx_last) begin
      if (fifo_cnt_reg == `STS_FIFO_DEPTH && !rd_fifo) begin
        overrun_next = 1'b1;
      end else begin
        fifo_we = 1'b1;
        if (!rd_fifo) begin
          fifo_cnt_next = fifo_cnt_reg + 2'h1;
        end
      end
    end else if (rd_fifo) begin
      fifo_cnt_next = fifo_cnt_reg - 2'h1;
    end
    if (rd_fifo) begin
      fifo_rd_next = ~fifo_rd_reg;
    end
  end

  // receive registers and fifo storage
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_shift_reg <= 9'h000;
      rx_cnt_reg   <= 4'h0;
      fifo_rd_reg  <= 1'b0;
      fifo_cnt_reg <= 2'h0;
      overrun_reg  <= 1'b0;
      fifo_mem[0]  <= 9'h000;
      fifo_mem[1]  <= 9'h000;
    end else begin
      rx_shift_reg <= rx_shift_next;
      rx_cnt_reg   <= rx_cnt_next;
      fifo_rd_reg  <= fifo_rd_next;
      fifo_cnt_reg <= fifo_cnt_next;
      overrun_reg  <= overrun_next;
      if (fifo_we) begin
        fifo_mem[fifo_wa] <= rx_shift_in;
      end
    end
  end

endmodule // sts_usart_slave

// file: shared/sts_defs.vh
`ifndef STS_DEFS_VH
`define STS_DEFS_VH
// register byte offsets
`define STS_OFF_INTCTL   8'h00
`define STS_OFF_PIE      8'h04
`define STS_OFF_PIR      8'h08
`define STS_OFF_RSC      8'h0C
`define STS_OFF_TXBUF    8'h10
`define STS_OFF_TSC      8'h14
`define STS_OFF_RXFIFO   8'h18
`define STS_OFF_SLEEP    8'h1C
// interrupt_master_control bits
`define STS_INTCTL_GLOBAL_EN 7
`define STS_INTCTL_PERIPH_EN 6
// peripheral irq enable / flag bits
`define STS_PI_RC        5
`define STS_PI_TX        4
// receive_status_control bits
`define STS_RSC_PORT_EN  7
`define STS_RSC_RX_NINE  6
`define STS_RSC_RX_ONCE  5
`define STS_RSC_RX_CONT  4
`define STS_RSC_ADDR_DET 3
`define STS_RSC_OVERRUN  1
`define STS_RSC_RX_BIT8  0
// transmit_status_control bits
`define STS_TSC_CLK_SRC  7
`define STS_TSC_TX_NINE  6
`define STS_TSC_TX_EN    5
`define STS_TSC_SYNC     4
`define STS_TSC_SR_EMPTY 1
`define STS_TSC_TX_BIT8  0
// character lengths in link clocks, and receive fifo depth
`define STS_BITS_BYTE    4'h8
`define STS_BITS_NINE    4'h9
`define STS_FIFO_DEPTH   2'h2
// reset values
`define STS_RST_TSC      8'h02
`define STS_RST_BYTE     8'h00
// interrupt vector address
`define STS_ISR_VECTOR   16'h0004
// axi responses
`define STS_RESP_OKAY    2'b00
`define STS_RESP_SLVERR  2'b10
`endif

// file: test/sts_chk.sv
`timescale 1ns/1ps
`include "sts_defs.vh"
module sts_chk #(
  parameter ADDR_W = 8
) (
  input wire              aclk,
  input wire              aresetn,
  input wire              s_axi_awvalid,
  input wire              s_axi_wvalid,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready,
  input wire [1:0]        s_axi_rresp,
  input wire              clock_pin_i,
  input wire              clock_pin_oe_n,
  input wire              data_pin_o,
  input wire              data_pin_oe_n,
  input wire              wake,
  input wire              vector_isr,
  input wire [15:0]       vector_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pin ownership and vector
  clk_drv_off_a: assert property (clock_pin_oe_n == 1'b1)
    else $error("clock pin driven");
  vec_fixed_a: assert property (vector_addr == `STS_ISR_VECTOR)
    else $error("vector address wrong");
  isr_wake_a: assert property (vector_isr |-> wake)
    else $error("vector without wake");
  // bus answer timing
  wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("late write answer");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("late read answer");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
  rd_unmapped_a: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 8'h1C
    |=> s_axi_rresp == `STS_RESP_SLVERR) else $error("unmapped read accepted");
  // data must hold across the trailing edge
  data_stable_a: assert property ($fell(clock_pin_i) && !data_pin_oe_n |->
    $stable(data_pin_o) ##1 $stable(data_pin_o)) else $error("data moved at trailing edge");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (!data_pin_oe_n);
  cover property (wake);
endmodule // sts_chk
bind sts_usart_slave sts_chk #(.ADDR_W(ADDR_W)) chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rresp, .clock_pin_i, .clock_pin_oe_n, .data_pin_o, .data_pin_oe_n,
  .wake, .vector_isr, .vector_addr);

// file: test/sts_sync_master.sv
`timescale 1ns/1ps
module sts_sync_master (
  output reg  clk_o,
  output reg  dat_o,
  input  wire line_i
);
  // clock idles low outside frames
  initial begin
    clk_o = 1'b0;
    dat_o = 1'b0;
  end
  // one frame: n clocks of 125 ns, data set mid-low, line sampled before the fall
  task automatic xfer(input int n, input logic [8:0] tx, output logic [8:0] rx);
    rx = '0;
    for (int i = 0; i < n; i++) begin
      #31.25 dat_o = tx[i];
      #31.25 clk_o = 1'b1;
      #62.5 rx[i] = line_i;
      clk_o = 1'b0;
    end
    #31.25 dat_o = ~dat_o; // released line shows the inverse of the last bit, after hold
  endtask
endmodule // sts_sync_master

// file: test/sts_usart_slave_tb.sv
`timescale 1ns/1ps
`include "sts_defs.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module sts_usart_slave_tb;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, m_clk, m_dat, data_pin_i;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        clock_pin_o, clock_pin_oe_n, data_pin_o, data_pin_oe_n, wake, vector_isr;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] vector_addr;
  int          compares = 0, n_fail = 0;
  sts_usart_slave #(.ADDR_W(8)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_pin_i(m_clk), .clock_pin_o,
    .clock_pin_oe_n, .data_pin_i, .data_pin_o, .data_pin_oe_n, .wake, .vector_isr, .vector_addr);
  sts_sync_master m_u (.clk_o(m_clk), .dat_o(m_dat), .line_i(data_pin_i));
  // shared data wire: whoever has the enable drives it
  assign data_pin_i = data_pin_oe_n ? m_dat : data_pin_o;
  always #5 aclk = ~aclk;
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er = `STS_RESP_OKAY);
    int k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready) && ++k < 99);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    do @(posedge aclk); while (!s_axi_bvalid && ++k < 99);
    s_axi_bready <= 1'b0;
    if (k >= 99) begin n_fail++; end_sim; end
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rc(input logic [7:0] a, e, input string nm, input logic [1:0] er = 0);
    int k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready && ++k < 99);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid && ++k < 99);
    s_axi_rready <= 1'b0;
    if (k >= 99) begin n_fail++; end_sim; end
    `CHK(nm, e, s_axi_rdata[7:0])
    `CHK("rresp", er, s_axi_rresp)
  endtask
  // main sequence: registers, slave transmit, slave receive
  initial begin
    logic [8:0] got;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`STS_OFF_TSC, `STS_RST_TSC, "tsc reset");
    rc(`STS_OFF_RSC, 8'h00, "rsc reset");
    rc(`STS_OFF_PIE, 8'h00, "pie reset");
    rc(8'h20, 8'h00, "unmapped", `STS_RESP_SLVERR);
    wr(8'h24, 8'h11, `STS_RESP_SLVERR);
    `CHK("ck drive", 2'b10, {clock_pin_oe_n, clock_pin_o})
    `CHK("vector", `STS_ISR_VECTOR, vector_addr)
    $display("register test done");
    wr(`STS_OFF_INTCTL, 8'hC0);
    wr(`STS_OFF_PIE, 8'h10);
    wr(`STS_OFF_RSC, 8'h80);
    wr(`STS_OFF_TSC, 8'h71);
    wr(`STS_OFF_TXBUF, 8'hA5);
    wr(`STS_OFF_TXBUF, 8'h3C);
    rc(`STS_OFF_PIR, 8'h00, "transmit_flag held");
    rc(`STS_OFF_TSC, 8'h71, "tsr busy");
    `CHK("tx dir", 1'b0, data_pin_oe_n)
    wr(`STS_OFF_SLEEP, 8'h01);
    m_u.xfer(9, 9'h000, got);
    `CHK("tx word1", 9'h1A5, got)
    repeat (6) @(posedge aclk);
    `CHK("tx wake", 1'b1, wake)
    `CHK("tx isr", 1'b1, vector_isr)
    rc(`STS_OFF_PIR, 8'h10, "transmit_flag set");
    rc(`STS_OFF_SLEEP, 8'h00, "awake");
    wr(`STS_OFF_TXBUF, 8'h5A);
    rc(`STS_OFF_PIR, 8'h00, "transmit_flag clear");
    `CHK("no wake", 1'b0, wake)
    m_u.xfer(9, 9'h000, got);
    `CHK("tx word2", 9'h13C, got)
    m_u.xfer(9, 9'h000, got);
    `CHK("tx word3", 9'h15A, got)
    repeat (6) @(posedge aclk);
    rc(`STS_OFF_TSC, 8'h73, "tsr empty");
    $display("transmit test done");
    wr(`STS_OFF_TSC, 8'h10);
    wr(`STS_OFF_PIE, 8'h20);
    wr(`STS_OFF_RSC, 8'hF0);
    `CHK("rx dir", 1'b1, data_pin_oe_n)
    m_u.xfer(9, 9'h155, got);
    m_u.xfer(9, 9'h0AA, got);
    m_u.xfer(9, 9'h1FF, got);
    repeat (6) @(posedge aclk);
    `CHK("rx wake", 1'b1, wake)
    rc(`STS_OFF_PIR, 8'h30, "receive_flag set");
    rc(`STS_OFF_RSC, 8'hF3, "overrun");
    rc(`STS_OFF_RXFIFO, 8'h55, "rx word1");
    rc(`STS_OFF_RSC, 8'hF2, "ninth bit");
    rc(`STS_OFF_RXFIFO, 8'hAA, "rx word2");
    rc(`STS_OFF_PIR, 8'h10, "receive_flag clear");
    wr(`STS_OFF_RSC, 8'hE0);
    rc(`STS_OFF_RSC, 8'hE0, "overrun off");
    $display("receive test done");
    end_sim;
  end
endmodule // sts_usart_slave_tb
